// >>> hw/fao_ctrl.sv
// fao_ctrl: fire alarm condition, silencing, reset, delayed outputs, indications
// assumes operator requests are one-cycle pulses synchronous to mclk
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - silence control at level 1 or 2 silences sounder and signalling output
// - sounder is never silenced automatically
// - silenced sounder re-sounds on a new zone, or same zone if configured
// - hidden fault/disable/test lamps revealed by level 1 or 2 operation
// - unrelated display info hidden in alarm unless separate window; recalls independent
// - temporarily hidden alarm fields return within 30 s
// - alarm condition left only by reset control at level 2
// - conditions still justified re-enter within 60 s after reset
// - reset completes, or shows progress, within 20 s
// - mandatory outputs within 3 s of alarm unless delayed
// - mandatory outputs within 10 s of a call point unless delayed
// - signalling devices disabled and re-enabled only at level 2
// - signalling re-activation modes: none, other zone, same zone
// - signalling activation shown on a never-hidden common indicator
// - routing transmission or acknowledgement indication latched until reset
// - protection output transmission shown on a common never-hidden red indicator
// - protection confirmation shown steady, transmission flashing, same indicator
// - delays set at level 3 in whole minutes up to 10
// - delay sources per output: detectors, call points, zones; routing no call points
// - level 1 action or call point cancels delays at once
// - each output delay runs on its own
// - delays switched at level 2 or by timer; on and running indicators
module fao_ctrl #(
  parameter int TICK_CYC = fao_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // operator panel
  input wire logic [2:0] acc_lvl,
  input wire fao_pkg::fao_ops_t ops,
  input wire logic timer_dly_on,
  input wire logic cfg_we,
  input wire fao_pkg::fao_cfg_t cfg_in,
  // alarm and feedback inputs
  input wire logic [fao_pkg::NZ-1:0] det_alarm,
  input wire logic [fao_pkg::NZ-1:0] mcp_alarm,
  input wire logic [fao_pkg::NZ-1:0] same_zone_evt,
  input wire logic route_ack,
  input wire logic prot_confirm,
  // equipment outputs
  output logic sig_drive,
  output logic route_drive,
  output logic prot_drive,
  // indications
  output var fao_pkg::fao_ind_t ind
);
  import fao_pkg::*;

  function automatic logic lvl_ok(input logic [2:0] lvl, input logic [2:0] lo, input logic [2:0] hi);
    return (lvl >= lo) && (lvl <= hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // one-second tick
  logic [31:0] tcnt, next_tcnt;
  logic tick, next_tick;
  logic blink, next_blink;

  always_comb begin
    next_tcnt = tcnt + 32'h1;
    next_tick = 1'b0;
    next_blink = blink;
    if (tcnt >= 32'(TICK_CYC - 1)) begin
      next_tcnt = '0;
      next_tick = 1'b1;
      next_blink = ~blink;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      tcnt <= '0;
      tick <= 1'b0;
      blink <= 1'b0;
    end else begin
      tcnt <= next_tcnt;
      tick <= next_tick;
      blink <= next_blink;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration, written only at level 3 or above
  fao_cfg_t cfg, next_cfg;

  always_comb begin
    next_cfg = cfg;
    if (cfg_we && lvl_ok(acc_lvl, LVL_CFG, LVL_TOP)) begin
      next_cfg = cfg_in;
      for (int k = 0; k < NOUT; k++) begin
        if (cfg_in.dly_min[k] > DLY_MAX_MIN) begin
          next_cfg.dly_min[k] = DLY_MAX_MIN;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg <= '0;
    end else begin
      cfg <= next_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm condition, silencing, reset and display
  fao_st_t st, next_st;
  logic [NZ-1:0] zones, next_zones;
  logic det_seen, next_det_seen;
  logic mcp_seen, next_mcp_seen;
  logic silenced, next_silenced;
  logic sig_sil, next_sig_sil;
  logic sig_dis, next_sig_dis;
  logic lamps, next_lamps;
  logic dly_man, next_dly_man;
  logic route_lat, next_route_lat;
  logic conf_lat, next_conf_lat;
  logic [3:0] recall, next_recall;
  logic fld_sup, next_fld_sup;
  logic [4:0] fld_cnt, next_fld_cnt;
  logic [NOUT-1:0] act_v, pend_v;

  wire logic ok12 = lvl_ok(acc_lvl, LVL_OP, LVL_AUTH);
  wire logic ok2up = lvl_ok(acc_lvl, LVL_AUTH, LVL_TOP);
  wire logic ok1up = lvl_ok(acc_lvl, LVL_OP, LVL_TOP);
  wire logic [NZ-1:0] zin = det_alarm | mcp_alarm;
  wire logic fire = |zones;
  wire logic new_any = |(zin & ~zones);
  wire logic same_any = |(same_zone_evt & zones);
  wire logic dly_on_w = cfg.timer_en ? timer_dly_on : dly_man;
  wire logic ovr = (ops.override && ok1up) || (|mcp_alarm);

  always_comb begin
    next_st = st;
    next_zones = zones;
    next_det_seen = det_seen;
    next_mcp_seen = mcp_seen;
    next_silenced = silenced;
    next_sig_sil = sig_sil;
    next_lamps = lamps;
    next_route_lat = route_lat;
    next_conf_lat = conf_lat;
    next_recall = recall;
    next_fld_sup = fld_sup;
    next_fld_cnt = fld_cnt;
    next_sig_dis = sig_dis;
    next_dly_man = dly_man;
    case (st)
      ST_RUN: begin
        next_zones = zones | zin;
        next_det_seen = det_seen | (|det_alarm);
        next_mcp_seen = mcp_seen | (|mcp_alarm);
        if (ops.silence && ok12 && fire) begin
          next_silenced = 1'b1;
          next_sig_sil = 1'b1;
        end
        // a new alarm beats a silence in the same cycle for the sounder, and for signalling unless react is REACT_NONE
        if (new_any || (same_any && cfg.react == REACT_SAME)) begin
          next_silenced = 1'b0;
        end
        if ((new_any && cfg.react != REACT_NONE) || (same_any && cfg.react == REACT_SAME)) begin
          next_sig_sil = 1'b0;
        end
        if (ops.reveal && ok12 && fire) begin
          next_lamps = 1'b1;
        end
        if (route_drive || route_ack) begin
          next_route_lat = 1'b1;
        end
        if (prot_confirm && fire) begin
          next_conf_lat = 1'b1;
        end
        if (fld_sup && tick) begin
          if (fld_cnt >= FIELD_TICKS) begin
            next_fld_sup = 1'b0;
            next_recall = '0;
          end else begin
            next_fld_cnt = fld_cnt + 5'h1;
          end
        end
        if ((|ops.recall) && ok12 && fire) begin
          next_recall = recall | ops.recall;
          next_fld_sup = 1'b1;
          next_fld_cnt = '0;
        end
        if (ops.reset && ok2up && fire) begin
          next_st = ST_RESET;
        end
      end
      ST_RESET: begin
        next_zones = '0;
        next_det_seen = 1'b0;
        next_mcp_seen = 1'b0;
        next_silenced = 1'b0;
        next_sig_sil = 1'b0;
        next_lamps = 1'b0;
        next_route_lat = 1'b0;
        next_conf_lat = 1'b0;
        next_recall = '0;
        next_fld_sup = 1'b0;
        next_fld_cnt = '0;
        // done at the next tick, far inside the permitted reset time
        if (tick) begin
          next_st = ST_RUN;
        end
      end
      default: next_st = ST_RUN;
    endcase
    // only an operator ever disables the signalling devices
    if (ops.sig_dis && ok2up) begin
      next_sig_dis = 1'b1;
    end else if (ops.sig_en && ok2up) begin
      next_sig_dis = 1'b0;
    end
    if (ops.dly_on && ok2up) begin
      next_dly_man = 1'b1;
    end else if (ops.dly_off && ok2up) begin
      next_dly_man = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= ST_RUN;
      zones <= '0;
      det_seen <= 1'b0;
      mcp_seen <= 1'b0;
      silenced <= 1'b0;
      sig_sil <= 1'b0;
      sig_dis <= 1'b0;
      lamps <= 1'b0;
      dly_man <= 1'b0;
      route_lat <= 1'b0;
      conf_lat <= 1'b0;
      recall <= '0;
      fld_sup <= 1'b0;
      fld_cnt <= '0;
    end else begin
      st <= next_st;
      zones <= next_zones;
      det_seen <= next_det_seen;
      mcp_seen <= next_mcp_seen;
      silenced <= next_silenced;
      sig_sil <= next_sig_sil;
      sig_dis <= next_sig_dis;
      lamps <= next_lamps;
      dly_man <= next_dly_man;
      route_lat <= next_route_lat;
      conf_lat <= next_conf_lat;
      recall <= next_recall;
      fld_sup <= next_fld_sup;
      fld_cnt <= next_fld_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-output delay; each output has its own counter
  for (genvar k = 0; k < NOUT; k++) begin : g_out
    logic act, next_act;
    logic pend, next_pend;
    logic [9:0] cnt, next_cnt;
    wire logic mcp_src = cfg.sel_mcp[k] && mcp_seen && (k != OUT_ROUTE);
    wire logic src_hit = (cfg.sel_det[k] && det_seen) || mcp_src || (|(cfg.sel_zone[k] & zones));
    wire logic [9:0] limit = 10'(cfg.dly_min[k]) * 10'(SEC_PER_MIN);

    always_comb begin
      next_act = act;
      next_pend = pend;
      next_cnt = cnt;
      if (st == ST_RESET) begin
        next_act = 1'b0;
        next_pend = 1'b0;
        next_cnt = '0;
      end else if (fire && !act) begin
        if (!dly_on_w || !src_hit || ovr) begin
          next_act = 1'b1;
          next_pend = 1'b0;
        end else if (cnt >= limit) begin
          next_act = 1'b1;
          next_pend = 1'b0;
        end else begin
          next_pend = 1'b1;
          if (tick) begin
            next_cnt = cnt + 10'h001;
          end
        end
      end
    end

    always_ff @(posedge mclk) begin
      if (rst) begin
        act <= 1'b0;
        pend <= 1'b0;
        cnt <= '0;
      end else begin
        act <= next_act;
        pend <= next_pend;
        cnt <= next_cnt;
      end
    end

    assign act_v[k] = act;
    assign pend_v[k] = pend;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs and indications
  assign sig_drive = act_v[OUT_SIG] && !sig_dis && !sig_sil;
  assign route_drive = act_v[OUT_ROUTE];
  assign prot_drive = act_v[OUT_PROT];

  always_comb begin
    ind.fire = fire;
    ind.sounder = fire && !silenced && (st == ST_RUN);
    ind.sig_ind = sig_drive;
    ind.route_ind = route_lat;
    // steady for confirmation, flashing for transmission only
    ind.prot_ind = conf_lat || (prot_drive && blink);
    ind.dly_on_ind = dly_on_w;
    ind.dly_run_ind = |pend_v;
    ind.reset_busy = (st == ST_RESET);
    ind.lamps_shown = !fire || lamps;
    ind.other_shown = !fire || cfg.sep_window;
    ind.fields_shown = !fld_sup;
    ind.recall_shown = recall;
    ind.sig_disabled = sig_dis;
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  a_silence_level: assert property (@(posedge mclk) disable iff (rst)
    $rose(silenced) |-> $past(ops.silence) && $past(ok12))
    else $error("silence latched without a level 1 or 2 request");

  a_no_auto_silence: assert property (@(posedge mclk) disable iff (rst)
    $fell(ind.sounder) && fire && st == ST_RUN && $past(st) == ST_RUN |-> $past(ops.silence) && $past(ok12))
    else $error("sounder silenced without the silence control");

  a_resound_zone: assert property (@(posedge mclk) disable iff (rst)
    st == ST_RUN && new_any && next_st == ST_RUN |=> ind.sounder)
    else $error("new zone did not re-sound the sounder");

  a_reset_enter: assert property (@(posedge mclk) disable iff (rst)
    st == ST_RUN && ops.reset && ok2up && fire |=> ind.reset_busy && !ind.sounder ##1 !fire)
    else $error("reset request not taken");

  a_alarm_exit: assert property (@(posedge mclk) disable iff (rst)
    $fell(fire) |-> $past(st) == ST_RESET)
    else $error("alarm condition left without reset");

  a_reset_short: assert property (@(posedge mclk) disable iff (rst)
    st == ST_RESET && tick |=> st == ST_RUN && !ind.reset_busy)
    else $error("reset not finished at the tick");

  a_rearm_alarm: assert property (@(posedge mclk) disable iff (rst)
    st == ST_RESET && tick ##1 (|zin) |=> fire)
    else $error("standing alarm not re-entered after reset");

  a_route_latch: assert property (@(posedge mclk) disable iff (rst)
    st == ST_RUN && next_st == ST_RUN && (route_ack || route_drive) |=> ind.route_ind [*2])
    else $error("routing indication not held");

  a_no_auto_disable: assert property (@(posedge mclk) disable iff (rst)
    $changed(sig_dis) |-> $past(ok2up) && ($past(ops.sig_dis) || $past(ops.sig_en)))
    else $error("signalling disable changed without level 2 request");

  a_override_now: assert property (@(posedge mclk) disable iff (rst)
    st == ST_RUN && next_st == ST_RUN && fire && ovr |=> act_v == {NOUT{1'b1}} && !ind.dly_run_ind)
    else $error("override did not activate all outputs");

  a_undelayed_out: assert property (@(posedge mclk) disable iff (rst)
    st == ST_RUN && next_st == ST_RUN && fire && !dly_on_w |=> act_v == {NOUT{1'b1}})
    else $error("undelayed outputs not active next cycle");

  a_fields_back: assert property (@(posedge mclk) disable iff (rst)
    st == ST_RUN && fld_sup && tick && fld_cnt >= FIELD_TICKS && !(|ops.recall) |=> ind.fields_shown)
    else $error("alarm fields not restored");

endmodule // fao_ctrl

`default_nettype wire

// >>> hw/fao_pkg.sv
// fao_pkg: constants, modes and carrier types of the fire alarm output control
// assumes one 20 MHz system clock; all long times are counted in one-second ticks
package fao_pkg;

  localparam int NZ = 8;
  localparam int NOUT = 3;
  localparam int OUT_SIG = 0;
  localparam int OUT_ROUTE = 1;
  localparam int OUT_PROT = 2;

  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_S = 1;
  localparam int TICK_CYC = CLK_HZ * TICK_S;
  localparam int FIELD_S = 30;
  localparam logic [4:0] FIELD_TICKS = 5'(FIELD_S / TICK_S - 1);
  localparam int SEC_PER_MIN = 60;
  localparam logic [3:0] DLY_MAX_MIN = 4'hA;

  localparam logic [2:0] LVL_OP = 3'h1;
  localparam logic [2:0] LVL_AUTH = 3'h2;
  localparam logic [2:0] LVL_CFG = 3'h3;
  localparam logic [2:0] LVL_TOP = 3'h4;

  localparam int REC_FAULT = 0;
  localparam int REC_DISABLE = 1;
  localparam int REC_TEST = 2;
  localparam int REC_SUPV = 3;

  typedef enum logic [1:0] {REACT_NONE, REACT_OTHER, REACT_SAME} fao_react_t;
  typedef enum logic {ST_RUN, ST_RESET} fao_st_t;

  typedef struct packed {
    fao_react_t react;
    logic sep_window;
    logic timer_en;
    logic [NOUT-1:0][3:0] dly_min;
    logic [NOUT-1:0] sel_det;
    logic [NOUT-1:0] sel_mcp;
    logic [NOUT-1:0][NZ-1:0] sel_zone;
  } fao_cfg_t;

  typedef struct packed {
    logic silence;
    logic reveal;
    logic [3:0] recall;
    logic reset;
    logic sig_dis;
    logic sig_en;
    logic override;
    logic dly_on;
    logic dly_off;
  } fao_ops_t;

  typedef struct packed {
    logic fire;
    logic sounder;
    logic sig_ind;
    logic route_ind;
    logic prot_ind;
    logic dly_on_ind;
    logic dly_run_ind;
    logic reset_busy;
    logic lamps_shown;
    logic other_shown;
    logic fields_shown;
    logic [3:0] recall_shown;
    logic sig_disabled;
  } fao_ind_t;

endpackage

// >>> tb/fao_equip.sv
// fao_equip: routing and protection equipment answering the output drives
// assumes drives are registered levels on mclk
`timescale 1ns/1ps
`default_nettype none
module fao_equip #(
  parameter int ACK_CYC = 8,
  parameter int CONF_CYC = 30
) (
  // clock
  input wire logic mclk,
  // drives from the panel
  input wire logic route_drive,
  input wire logic prot_drive,
  // answers to the panel
  output logic route_ack,
  output logic prot_confirm
);
  int rc;
  int pc;
  // answers drop with the drive, so a latch in the panel is really needed
  always_ff @(posedge mclk) begin
    rc <= route_drive ? rc + 1 : 0;
    pc <= prot_drive ? pc + 1 : 0;
  end
  // confirm slower than a tick so the transmitting blink is seen first
  assign route_ack = (rc >= ACK_CYC);
  assign prot_confirm = (pc >= CONF_CYC);
endmodule // fao_equip
`default_nettype wire

// >>> tb/tb_top.sv
// tb_top: self-checking bench of fao_ctrl with a short tick
// assumes outputs settle within 5 ns of the rising edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("Error %s exp %0h got %0h", n, e, a); end end
module tb_top;
  import fao_pkg::*;
  localparam int T = 20;
  logic mclk, rst, timer_dly_on, cfg_we, route_ack, prot_confirm;
  logic sig_drive, route_drive, prot_drive;
  logic [2:0] acc_lvl;
  logic [NZ-1:0] det, mcp, sze;
  fao_ops_t ops, ops_q;
  fao_cfg_t cfg_in;
  fao_ind_t ind;
  int errors, checks_done, cyc, z, k;
  logic [7:0] rnd;
  logic blk;
  fao_ctrl #(.TICK_CYC(T)) i_dut (.mclk(mclk), .rst(rst), .acc_lvl(acc_lvl),
    .ops(ops_q), .timer_dly_on(timer_dly_on), .cfg_we(cfg_we), .cfg_in(cfg_in),
    .det_alarm(det), .mcp_alarm(mcp), .same_zone_evt(sze), .route_ack(route_ack),
    .prot_confirm(prot_confirm), .sig_drive(sig_drive), .route_drive(route_drive),
    .prot_drive(prot_drive), .ind(ind));
  fao_equip i_equip (.mclk(mclk), .route_drive(route_drive),
    .prot_drive(prot_drive), .route_ack(route_ack), .prot_confirm(prot_confirm));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic resound(input int m);
    return m == 2;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #5;
  endtask
  // request bits are staged in ops by the caller, then held for exactly one edge;
  // one idle edge first, so back-to-back pulses never re-raise a bit just dropped
  task automatic pulse(input logic [2:0] l);
    step(1);
    ops_q = ops;
    acc_lvl = l;
    step(1);
    ops_q = '0;
    ops = '0;
  endtask
  task automatic setcfg(input int m, input logic [3:0] d, input logic [2:0] sel);
    cfg_in = '0;
    cfg_in.react = fao_react_t'(m);
    cfg_in.dly_min = {3{d}};
    cfg_in.sel_det = sel;
    cfg_we = 1'b1;
    acc_lvl = 3'h3;
    step(1);
    cfg_we = 1'b0;
  endtask
  task automatic areset(input logic keep);
    if (!keep) begin
      det = '0;
      mcp = '0;
    end
    ops.reset = 1'b1;
    pulse(3'h2);
    `CHK("busy", 1'b1, ind.reset_busy)
    for (int i = 0; i < T + 2 && ind.reset_busy !== 1'b0; i++) step(1);
    `CHK("busy", 1'b0, ind.reset_busy)
    step(2);
    `CHK("fire", keep, ind.fire)
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      test_done;
    end
  end
  initial begin
    {rst, timer_dly_on, cfg_we, det, mcp, sze, acc_lvl} = '0;
    rst = 1'b1;
    ops = '0;
    ops_q = '0;
    cfg_in = '0;
    rnd = 8'h27;
    step(8);
    rst = 1'b0;
    `CHK("drv", 3'h0, {sig_drive, route_drive, prot_drive})
    `CHK("shown", 3'h7, {ind.lamps_shown, ind.other_shown, ind.fields_shown})
    rnd = lfsr(rnd);
    z = rnd[2:0];
    k = rnd[4:3];
    // plain alarm, indications and operator controls
    det[z] = 1'b1;
    step(1);
    `CHK("fire", 2'h3, {ind.fire, ind.sounder})
    step(1);
    `CHK("drv", 3'h7, {sig_drive, route_drive, prot_drive})
    `CHK("sig_ind", 1'b1, ind.sig_ind)
    `CHK("other", 1'b0, ind.other_shown)
    step(2);
    // one tick lies in any window of T cycles, so transmission must have toggled
    blk = ind.prot_ind;
    step(10);
    `CHK("route_ind", 1'b1, ind.route_ind)
    step(10);
    `CHK("prot_ind", ~blk, ind.prot_ind)
    step(30);
    `CHK("prot_ind", 1'b1, ind.prot_ind)
    step(25);
    `CHK("prot_ind", 1'b1, ind.prot_ind)
    ops.reveal = 1'b1;
    pulse(3'h1);
    `CHK("lamps", 1'b1, ind.lamps_shown)
    ops.recall[k] = 1'b1;
    pulse(3'h2);
    `CHK("recall", 4'(1 << k), ind.recall_shown)
    `CHK("fields", 1'b0, ind.fields_shown)
    step(30 * T + 2);
    `CHK("fields", 1'b1, ind.fields_shown)
    ops.silence = 1'b1;
    pulse(3'h3);
    `CHK("sounder", 1'b1, ind.sounder)
    ops.silence = 1'b1;
    pulse(3'h1);
    `CHK("sounder", 1'b0, ind.sounder)
    step(5 * T);
    `CHK("sounder", 1'b0, ind.sounder)
    ops.sig_dis = 1'b1;
    pulse(3'h1);
    `CHK("sig_dis", 1'b0, ind.sig_disabled)
    ops.sig_dis = 1'b1;
    pulse(3'h2);
    `CHK("sig_dis", 1'b1, ind.sig_disabled)
    ops.sig_en = 1'b1;
    pulse(3'h2);
    `CHK("sig_dis", 1'b0, ind.sig_disabled)
    ops.reset = 1'b1;
    pulse(3'h1);
    step(T + 2);
    `CHK("fire", 1'b1, ind.fire)
    areset(1'b1);
    areset(1'b0);
    `CHK("route_ind", 1'b0, ind.route_ind)
    // every re-activation mode after silencing
    for (int m = 0; m < 3; m++) begin
      setcfg(m, 4'h0, 3'h0);
      det[0] = 1'b1;
      step(2);
      ops.silence = 1'b1;
      pulse(3'h2);
      sze[0] = 1'b1;
      step(1);
      sze = '0;
      step(1);
      `CHK("resound", resound(m), ind.sounder)
      det[1] = 1'b1;
      step(2);
      `CHK("sounder", 1'b1, ind.sounder)
      `CHK("sig", logic'(m != 0), sig_drive)
      areset(1'b0);
    end
    // delayed outputs: signalling and protection delayed, routing free
    setcfg(0, 4'h1, 3'h5);
    ops.dly_on = 1'b1;
    pulse(3'h2);
    `CHK("dly_on", 1'b1, ind.dly_on_ind)
    det[z] = 1'b1;
    step(2);
    `CHK("drv", 3'h2, {sig_drive, route_drive, prot_drive})
    `CHK("dly_run", 1'b1, ind.dly_run_ind)
    step(58 * T);
    `CHK("sig", 1'b0, sig_drive)
    step(3 * T);
    `CHK("drv", 3'h7, {sig_drive, route_drive, prot_drive})
    areset(1'b0);
    det[z] = 1'b1;
    step(2);
    mcp[z] = 1'b1;
    step(2);
    `CHK("drv", 3'h7, {sig_drive, route_drive, prot_drive})
    areset(1'b0);
    det[z] = 1'b1;
    step(2);
    ops.override = 1'b1;
    pulse(3'h1);
    step(1);
    `CHK("drv", 3'h7, {sig_drive, route_drive, prot_drive})
    ops.dly_off = 1'b1;
    pulse(3'h2);
    `CHK("dly_on", 1'b0, ind.dly_on_ind)
    areset(1'b0);
    // timer-switched delay on signalling only, oversize setting clamped, separate alarm window
    cfg_in = '0;
    cfg_in.dly_min = {3{4'hF}};
    cfg_in.sel_det = 3'h1;
    cfg_in.sep_window = 1'b1;
    cfg_in.timer_en = 1'b1;
    cfg_we = 1'b1;
    acc_lvl = 3'h3;
    step(1);
    cfg_we = 1'b0;
    timer_dly_on = 1'b1;
    det[z] = 1'b1;
    step(2);
    `CHK("dly_on", 1'b1, ind.dly_on_ind)
    `CHK("other", 1'b1, ind.other_shown)
    `CHK("drv", 3'h3, {sig_drive, route_drive, prot_drive})
    step((int'(DLY_MAX_MIN) * SEC_PER_MIN - 2) * T);
    `CHK("sig", 1'b0, sig_drive)
    step(4 * T);
    `CHK("sig", 1'b1, sig_drive)
    timer_dly_on = 1'b0;
    step(1);
    `CHK("dly_on", 1'b0, ind.dly_on_ind)
    areset(1'b0);
    test_done;
  end
endmodule // tb_top
`default_nettype wire
